//--- ocs_map.vh
// constants for the output clock select and halt block
// assumes a one-clock design on mclk with a simple register write/read port
// Function
// - single-ended output three source: 00 engine2 divider D, 01 engine0 divider D
// - differential pair: output three is inverted output two, source field ignored
// - halt field 00/01 run, 10 halt low at fall, 11 halt high at rise
// - engine3 bank bits 1:0..7:6 halt dividers A..D, outputs four to seven
// - engine2 bank bits 1:0..7:6 halt dividers A..D, outputs zero to three; bits 7:6 are ignored with the differential pair
`ifndef OCS_MAP_VH
`define OCS_MAP_VH
`define OCS_ADDR_SRC_LOW 8'hB5
`define OCS_ADDR_HALT_E3 8'hB6
`define OCS_ADDR_HALT_E2 8'hB7
`define OCS_RST_VAL 8'h00
`define OCS_SRC3_MSB 7
`define OCS_SRC3_LSB 6
`define OCS_SEL_E2D 2'h0
`define OCS_SEL_E0D 2'h1
`define OCS_HALT_LOW 2'h2
`define OCS_HALT_HIGH 2'h3
`endif

//--- ocs_top.v
// output clock source select for output three and per-divider halt control
// assumes divided clocks are slow against mclk and sampled here as ordinary inputs
`timescale 1ns/100ps
`default_nettype none
`include "ocs_map.vh"
module ocs_top (
	input wire mclk,
	input wire rst,
	input wire reg_wr,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	input wire diff_pair_23,
	input wire engine2_divider_d,
	input wire engine0_divider_d,
	input wire [3:0] engine2_div_in,
	input wire [3:0] engine3_div_in,
	output reg [7:0] output_clock,
	output reg [7:0] halted
);
	// register file, written and read on mclk
	reg [7:0] output_source_select_low_r;
	reg [7:0] engine3_halt_control_r;
	reg [7:0] engine2_halt_control_r;
	reg [7:0] rdata_nxt;
	// synchroniser stages: divider clocks come from their own synthesizer domains
	reg [7:0] div_s1_r;
	reg [7:0] div_s2_r;
	reg e2d_s1_r;
	reg e2d_s2_r;
	reg e0d_s1_r;
	reg e0d_s2_r;
	// per-output hold state
	reg [7:0] hold_r;
	wire [7:0] hold_nxt;
	wire [7:0] out_nxt;
	wire [7:0] live;
	wire [7:0] div_raw;
	wire [15:0] halt_bank;
	wire [1:0] src3_sel;
	wire src3_clk;
	genvar g;

	// a field asks for a halt when its upper bit is set
	function halt_req;
		input [1:0] code;
		begin
			halt_req = code[1];
		end
	endfunction

	// level at which a halted output rests: 10 low, 11 high
	function halt_level;
		input [1:0] code;
		begin
			halt_level = code[0];
		end
	endfunction

	// address match shared by the write and read paths
	function addr_hit;
		input [7:0] addr;
		input [7:0] target;
		begin
			addr_hit = (addr == target);
		end
	endfunction

	// reserved codes give a quiet low rather than an arbitrary clock
	function src3_pick;
		input [1:0] sel;
		input e2d;
		input e0d;
		begin
			case (sel)
				`OCS_SEL_E2D: src3_pick = e2d;
				`OCS_SEL_E0D: src3_pick = e0d;
				default: src3_pick = 1'h0;
			endcase
		end
	endfunction

	// next hold state of one output: engage at the rest level, release on a level match
	function hold_step;
		input held;
		input halt_on;
		input live_lvl;
		input out_lvl;
		input rest_lvl;
		begin
			if (held)
				hold_step = halt_on || (live_lvl != out_lvl);
			else
				hold_step = halt_on && (live_lvl == rest_lvl);
		end
	endfunction

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			output_source_select_low_r <= `OCS_RST_VAL;
		end else if (reg_wr && addr_hit(reg_addr, `OCS_ADDR_SRC_LOW)) begin
			output_source_select_low_r <= reg_wdata;
		end
	end

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			engine3_halt_control_r <= `OCS_RST_VAL;
		end else if (reg_wr && addr_hit(reg_addr, `OCS_ADDR_HALT_E3)) begin
			engine3_halt_control_r <= reg_wdata;
		end
	end

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			engine2_halt_control_r <= `OCS_RST_VAL;
		end else if (reg_wr && addr_hit(reg_addr, `OCS_ADDR_HALT_E2)) begin
			engine2_halt_control_r <= reg_wdata;
		end
	end

	// read mux; unmapped addresses read as zero
	always @* begin
		rdata_nxt = 8'h00;
		if (addr_hit(reg_addr, `OCS_ADDR_SRC_LOW))
			rdata_nxt = output_source_select_low_r;
		if (addr_hit(reg_addr, `OCS_ADDR_HALT_E3))
			rdata_nxt = engine3_halt_control_r;
		if (addr_hit(reg_addr, `OCS_ADDR_HALT_E2))
			rdata_nxt = engine2_halt_control_r;
	end

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			reg_rdata <= `OCS_RST_VAL;
		end else begin
			reg_rdata <= rdata_nxt;
		end
	end

	assign src3_sel = output_source_select_low_r[`OCS_SRC3_MSB:`OCS_SRC3_LSB];
	// fields in output order: engine2 A..D drive 0..3, engine3 A..D drive 4..7
	assign halt_bank = {engine3_halt_control_r, engine2_halt_control_r};
	assign div_raw = {engine3_div_in, engine2_div_in};

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			div_s1_r <= 8'h00;
			div_s2_r <= 8'h00;
		end else begin
			div_s1_r <= div_raw;
			div_s2_r <= div_s1_r;
		end
	end

	// both candidates are synchronised before the mux, not after it
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			e2d_s1_r <= 1'h0;
			e2d_s2_r <= 1'h0;
		end else begin
			e2d_s1_r <= engine2_divider_d;
			e2d_s2_r <= e2d_s1_r;
		end
	end

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			e0d_s1_r <= 1'h0;
			e0d_s2_r <= 1'h0;
		end else begin
			e0d_s1_r <= engine0_divider_d;
			e0d_s2_r <= e0d_s1_r;
		end
	end

	assign src3_clk = src3_pick(src3_sel, e2d_s2_r, e0d_s2_r);

	// engaging only at the rest level keeps the last pulse whole, and releasing only on a
	// level match means no runt pulse follows the release
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_out
			wire [1:0] code;
			wire bypass;
			wire halt_on;
			assign code = halt_bank[2*g+1:2*g];
			if (g == 3) begin : g_three
				// a differential pair drives the inverse of output two; its own halt field has no effect
				assign live[g] = diff_pair_23 ? ~out_nxt[2] : src3_clk;
				assign bypass = diff_pair_23;
			end else begin : g_plain
				assign live[g] = div_s2_r[g];
				assign bypass = 1'h0;
			end
			assign halt_on = halt_req(code) && !bypass;
			assign hold_nxt[g] = !bypass && hold_step(hold_r[g], halt_on, live[g],
				output_clock[g], halt_level(code));
			assign out_nxt[g] = (hold_r[g] && !bypass) ? output_clock[g] : live[g];
		end
	endgenerate

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			hold_r <= 8'h00;
		end else begin
			hold_r <= hold_nxt;
		end
	end

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			output_clock <= 8'h00;
		end else begin
			output_clock <= out_nxt;
		end
	end

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			halted <= 8'h00;
		end else begin
			halted <= hold_nxt;
		end
	end
endmodule // ocs_top
`default_nettype wire

//--- ocs_sva.sv
// ocs_top port assertions
// bound into ocs_top, mclk only
`timescale 1ns/100ps
`default_nettype none
module ocs_sva (
	input wire logic mclk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic diff_pair_23,
	input wire logic engine0_divider_d,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic [7:0] output_clock,
	input wire logic [7:0] halted,
	input wire logic [3:0] engine2_div_in,
	input wire logic [3:0] engine3_div_in
);
	logic [1:0] sel_r;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// shadow of the output three source field, needed to predict the mux
	always @(posedge mclk) sel_r <= rst ? 2'h0 : (reg_wr && reg_addr == 8'hB5) ? reg_wdata[7:6] : sel_r;
	a_e3_follow: assert property ((halted[7:4] == 4'h0)[*4]
		|-> output_clock[7:4] == $past(engine3_div_in, 3)) else $error("e3 path");
	a_e2_follow: assert property ((halted[2:0] == 3'h0)[*4]
		|-> output_clock[2:0] == $past(engine2_div_in[2:0], 3)) else $error("e2 path");
	a_src_pick: assert property ((sel_r == 2'h1 && !diff_pair_23 && !halted[3])[*4]
		|-> output_clock[3] == $past(engine0_divider_d, 3)) else $error("source");
	a_diff_inv: assert property (diff_pair_23[*2] |-> output_clock[3] != output_clock[2])
		else $error("diff");
	a_halt_freeze: assert property (((output_clock ^ $past(output_clock))
		& halted & $past(halted)) == 8'h00) else $error("freeze");
	a_read_back: assert property (reg_wr && reg_addr == 8'hB6 ##1 reg_addr == 8'hB6
		|=> reg_rdata == $past(reg_wdata, 2)) else $error("readback");
	a_rd_unmap: assert property (reg_addr < 8'hB5 || reg_addr > 8'hB7 |=> reg_rdata == 8'h00)
		else $error("unmapped");
	a_rst_clear: assert property ($fell(rst) |-> {output_clock, halted} == 16'h0000)
		else $error("reset");
	cover property ($rose(halted[4]));
	cover property (diff_pair_23 && halted[2]);
	cover property (sel_r == 2'h1 && !diff_pair_23);
endmodule // ocs_sva
bind ocs_top ocs_sva i_ocs_sva(.*);
`default_nettype wire

//--- output_clock_select_and_stop_tb.sv
// bench for ocs_top
// drives on falling mclk, checks via queue
`timescale 1ns/100ps
`default_nettype none
module output_clock_select_and_stop_tb;
	logic mclk=0, rst=1, reg_wr=0, diff_pair_23=0, engine2_divider_d=0, engine0_divider_d=0;
	logic [7:0] reg_addr=0, reg_wdata=0, reg_rdata, output_clock, halted;
	logic [3:0] engine2_div_in=0, engine3_div_in=0;
	logic [16:0] exp_q[$];
	logic rd_p=0, rd_d=0;
	int errors=0, checked=0;
	logic fix_in=0;
	logic [9:0] fix_val=0;
	logic [16:0] e_w;
	ocs_top i_ocs_top(.*);
	initial forever #12.5 mclk = ~mclk;
	always @(negedge mclk) {engine2_div_in, engine3_div_in, engine2_divider_d,
		engine0_divider_d} <= fix_in ? fix_val : 10'($urandom);
	always @(posedge mclk) rd_d <= rd_p;
	always @(negedge mclk) begin
		if (rd_d) begin
			e_w = exp_q.pop_front();
			if (e_w[16])
				cmp_out(e_w[15:0]);
			else
				cmp_rd(e_w[7:0]);
		end
	end
	task cmp_rd(input [7:0] e);
		checked++;
		if (reg_rdata !== e) begin
			errors++;
			$display("mismatch %0t readback exp %h got %h", $time, e, reg_rdata);
		end
	endtask
	task cmp_out(input [15:0] e);
		checked++;
		if ({halted, output_clock} !== e) begin
			errors++;
			$display("mismatch %0t outputs exp %h got %h", $time, e, {halted, output_clock});
		end
	endtask
	// bounded wait for a hold pattern; running out counts as a mismatch
	task wait_halted(input [7:0] v);
		int n;
		n = 0;
		while (n < 60 && halted !== v) begin
			@(negedge mclk);
			n++;
		end
		if (halted !== v) begin
			errors++;
			$display("mismatch %0t halt wait timed out", $time);
		end
	endtask
	task wr(input [7:0] a, d);
		@(negedge mclk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
		@(negedge mclk) reg_wr = 0;
	endtask
	// k selects outputs (1) or readback (0)
	task look(input k, input [15:0] e, input [7:0] a);
		@(negedge mclk) {reg_addr, rd_p} = {a, 1'b1};
		exp_q.push_back({k, e});
		@(negedge mclk) rd_p = 0;
	endtask
	task complete_run;
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		void'($urandom(57558));
		#100 rst = 0;
		for (int a = 8'hB4; a < 8'hB9; a++) look(0, 0, 8'(a));
		for (int c = 0; c < 4; c++) begin
			wr(8'hB5, 8'(c << 6));
			look(0, 16'(c << 6), 8'hB5);
			repeat (20) @(negedge mclk);
		end
		wr(8'hB5, 8'h00);
		wr(8'hB6, 8'hBE);
		wr(8'hB7, 8'hBE);
		wait_halted(8'hFF);
		look(1, 16'hFF66, 0);
		// fixed divider levels from here on make every output predictable
		fix_val = 10'h1A8;
		fix_in = 1;
		repeat (4) @(negedge mclk);
		wr(8'hB6, 8'h45);
		repeat (6) @(negedge mclk);
		look(1, 16'hCF66, 0);
		fix_val = 10'h198;
		repeat (6) @(negedge mclk);
		look(1, 16'h0F66, 0);
		wr(8'hB7, 8'h00);
		repeat (6) @(negedge mclk);
		look(1, 16'h0066, 0);
		fix_val = 10'h0EA;
		repeat (6) @(negedge mclk);
		look(1, 16'h00AB, 0);
		wr(8'hB5, 8'h40);
		repeat (6) @(negedge mclk);
		look(1, 16'h00A3, 0);
		fix_val = 10'h0E9;
		repeat (6) @(negedge mclk);
		look(1, 16'h00AB, 0);
		wr(8'hB5, 8'h80);
		repeat (6) @(negedge mclk);
		look(1, 16'h00A3, 0);
		// no engine0 clock goes to the pair, so synthesizer 0 need not be enabled
		diff_pair_23 = 1;
		repeat (6) @(negedge mclk);
		look(1, 16'h00AB, 0);
		complete_run;
	end
endmodule // output_clock_select_and_stop_tb
`default_nettype wire
